/* scm_sideband_ctrl.sv */
// Purpose: Sideband control and status of a pluggable transceiver module.
// Assumes: All pins synchronous to clk_i; management port is decoded 2-wire traffic.
// Notes:   Open-collector pins are split into level and output enable.
//
// Notes on behaviour
// - Select low lets management commands be taken and answered.
// - Select high ignores management traffic; no answer or data driven.
// - Undriven select reads as high through the internal pull-up.
// - Reset held longer than minimum resets module and restores user defaults.
// - Reset-complete timing starts at the rising edge ending the low level.
// - Completion shown by interrupt with initialization-pending flag cleared.
// - After power-up the completion interrupt is posted without a reset pulse.
// - Low-power request high puts module into its reduced-power state.
// - Presence pin tied low inside the module.
// - Interrupt pin low indicates fault or critical status.
// - Interrupt pin is open collector: pull low or release.
module scm_sideband_ctrl
#(
   parameter int unsigned CLK_PER_MS = scm_pkg::CLK_PER_MS_DEF,
   parameter int unsigned T_INIT_MS = scm_pkg::T_INIT_MS_DEF
)
(
   // Clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Module select pin with pull-up
   input wire logic module_select_n_i,
   input wire logic module_select_drv_i,
   // Module reset pin with pull-up
   input wire logic module_reset_n_i,
   input wire logic module_reset_drv_i,
   // Low-power request pin
   input wire logic low_power_request_i,
   // Internal fault and critical status events
   input wire logic [scm_pkg::FAULT_W-1:0] fault_event_i,
   // Management access port
   input wire logic [scm_pkg::ADDR_W-1:0] mgmt_addr_i,
   input wire logic [scm_pkg::DATA_W-1:0] mgmt_wdata_i,
   input wire logic mgmt_write_i,
   input wire logic mgmt_read_i,
   output logic [scm_pkg::DATA_W-1:0] mgmt_rdata_o,
   output logic mgmt_ack_o,
   // Presence pin, open drain
   output logic module_present_n_o,
   output logic module_present_n_oe_o,
   // Interrupt pin, open collector
   output logic interrupt_out_n_o,
   output logic interrupt_out_n_oe_o,
   // Power control towards the optics
   output logic low_power_o,
   output logic init_pending_o
);
   import scm_pkg::*;

   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_PER_MS - 1);
   localparam logic [MS_W-1:0] INIT_LAST = MS_W'(T_INIT_MS - 1);

   typedef struct packed {
      scm_state_t state;
      logic [DIV_W-1:0] div;
      logic [MS_W-1:0] ms;
      logic [FLAG_W-1:0] flags;
      logic [FLAG_W-1:0] mask;
      logic [CTRL_W-1:0] ctrl;
      logic [DATA_W-1:0] rdata;
      logic ack;
      logic init_pending;
      logic low_power;
      logic irq;
   } scm_state_bundle_t;

   scm_state_bundle_t s_q;
   scm_state_bundle_t s_d;

   // Pin levels after pull-ups
   logic select_n;
   logic reset_pin_n;
   logic selected;

   // Reset qualifier results
   logic rst_qualified;
   logic rst_released;

   // Timer compares and enable
   logic div_last;
   logic ms_last;
   logic ms_tick;
   logic done_event;

   // Management decode
   logic wr_en;
   logic rd_en;
   logic wr_flags;
   logic wr_mask;
   logic wr_ctrl;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] rd_mux;

   // Flag events
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;

   // Pull-ups on undriven pins
   assign select_n = module_select_drv_i ? module_select_n_i : 1'b1;
   assign reset_pin_n = module_reset_drv_i ? module_reset_n_i : 1'b1;
   assign selected = ~select_n;

   // Reset pulse length check
   scm_low_pulse_qual #(
      .MIN_CYCLES(RESET_MIN_CYC)
   ) u_reset_qual (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .level_n_i(reset_pin_n),
      .qualified_o(rst_qualified),
      .released_o(rst_released)
   );

   // Access gating by select
   assign wr_en = mgmt_write_i & selected;
   assign rd_en = mgmt_read_i & selected;

   // Millisecond enable from divider
   assign div_last = (s_q.div == DIV_LAST);
   assign ms_last = (s_q.ms == INIT_LAST);
   assign ms_tick = (s_q.state == SCM_INIT) && div_last;

   // Completion of the init interval
   assign done_event = ms_tick && ms_last;

   // Write decode by register index
   always_comb
   begin
      wr_flags = 1'b0;
      wr_mask = 1'b0;
      wr_ctrl = 1'b0;
      if (wr_en)
      begin
         case (mgmt_addr_i)
            REG_FLAGS:
            begin
               wr_flags = 1'b1;
            end
            REG_MASK:
            begin
               wr_mask = 1'b1;
            end
            REG_CONTROL:
            begin
               wr_ctrl = 1'b1;
            end
            default:
            begin
               wr_flags = 1'b0;
            end
         endcase
      end
   end

   // Hardware sets and software clears of flags
   always_comb
   begin
      flag_set = '0;
      flag_set[FLAG_RESET_DONE_BIT] = done_event;
      flag_set[FLAG_FAULT_LSB +: FAULT_W] = fault_event_i;
      flag_clr = '0;
      if (wr_flags)
      begin
         flag_clr = mgmt_wdata_i[FLAG_W-1:0];
      end
   end

   // Status word
   always_comb
   begin
      status_word = '0;
      status_word[ST_INIT_PENDING_BIT] = s_q.init_pending;
      status_word[ST_LOW_POWER_BIT] = s_q.low_power;
      status_word[ST_RESET_HELD_BIT] = rst_qualified;
   end

   // Read multiplexer
   always_comb
   begin
      rd_mux = '0;
      case (mgmt_addr_i)
         REG_STATUS:
         begin
            rd_mux = status_word;
         end
         REG_FLAGS:
         begin
            rd_mux[FLAG_W-1:0] = s_q.flags;
         end
         REG_MASK:
         begin
            rd_mux[FLAG_W-1:0] = s_q.mask;
         end
         REG_CONTROL:
         begin
            rd_mux[CTRL_W-1:0] = s_q.ctrl;
         end
         default:
         begin
            rd_mux = '0;
         end
      endcase
   end

   // Next-state logic
   always_comb
   begin
      s_d = s_q;

      // Register reads answer one cycle later
      s_d.ack = rd_en;
      s_d.rdata = rd_en ? rd_mux : '0;

      // Writes to user settings
      if (wr_mask)
      begin
         s_d.mask = mgmt_wdata_i[FLAG_W-1:0];
      end
      if (wr_ctrl)
      begin
         s_d.ctrl = mgmt_wdata_i[CTRL_W-1:0];
      end

      // Set wins over clear
      s_d.flags = (s_q.flags & ~flag_clr) | flag_set;

      case (s_q.state)
         SCM_RUN:
         begin
            s_d.div = '0;
            s_d.ms = '0;
            if (rst_qualified)
            begin
               s_d.state = SCM_HOLD;
            end
         end
         SCM_HOLD:
         begin
            s_d.div = '0;
            s_d.ms = '0;
            if (rst_released)
            begin
               s_d.state = SCM_INIT;
            end
         end
         SCM_INIT:
         begin
            if (rst_qualified)
            begin
               s_d.state = SCM_HOLD;
               s_d.div = '0;
               s_d.ms = '0;
            end
            else if (ms_tick)
            begin
               s_d.div = '0;
               if (done_event)
               begin
                  s_d.state = SCM_RUN;
                  s_d.init_pending = 1'b0;
               end
               else
               begin
                  s_d.ms = s_q.ms + 1'b1;
               end
            end
            else
            begin
               s_d.div = s_q.div + 1'b1;
            end
         end
         default:
         begin
            s_d.state = SCM_INIT;
            s_d.div = '0;
            s_d.ms = '0;
            s_d.init_pending = 1'b1;
         end
      endcase

      // Full module reset restores user defaults
      if (rst_qualified)
      begin
         s_d.mask = MASK_RST;
         s_d.ctrl = CTRL_RST;
         s_d.flags = FLAGS_RST;
         s_d.init_pending = 1'b1;
      end

      // Reduced-power state
      s_d.low_power = low_power_request_i | s_q.ctrl[CTRL_FORCE_LP_BIT];

      // Interrupt from unmasked flags
      s_d.irq = |(s_d.flags & ~s_d.mask);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         // Power-up begins an init interval
         s_q.state <= SCM_INIT;
         s_q.div <= '0;
         s_q.ms <= '0;
         s_q.flags <= FLAGS_RST;
         s_q.mask <= MASK_RST;
         s_q.ctrl <= CTRL_RST;
         s_q.rdata <= '0;
         s_q.ack <= 1'b0;
         s_q.init_pending <= 1'b1;
         s_q.low_power <= 1'b0;
         s_q.irq <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Management answers
   assign mgmt_rdata_o = s_q.rdata;
   assign mgmt_ack_o = s_q.ack;

   // Presence tied low inside the module
   assign module_present_n_o = 1'b0;
   assign module_present_n_oe_o = 1'b1;

   // Open-collector interrupt: pull low or release
   assign interrupt_out_n_o = 1'b0;
   assign interrupt_out_n_oe_o = s_q.irq;

   // Power and init status
   assign low_power_o = s_q.low_power;
   assign init_pending_o = s_q.init_pending;

endmodule

/* scm_pkg.sv */
// Purpose: Shared constants and types for the module sideband control block.
// Assumes: 20 MHz clock; 8-bit management address and data.
// Notes:   Register offsets are word indices on the management port.
package scm_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned T_RESET_MIN_NS = 10000;
   localparam int unsigned RESET_MIN_CYC =
      (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CLK_PER_MS_DEF = 1000000 / CLK_PERIOD_NS;
   localparam int unsigned T_INIT_MS_DEF = 2000;

   // Widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FAULT_W = 4;
   localparam int unsigned FLAG_W = FAULT_W + 1;
   localparam int unsigned DIV_W = 16;
   localparam int unsigned MS_W = 12;
   localparam int unsigned QCNT_W = 16;

   // Register offsets
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h01;
   localparam logic [ADDR_W-1:0] REG_MASK = 8'h02;
   localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h03;

   // Status fields
   localparam int unsigned ST_INIT_PENDING_BIT = 0;
   localparam int unsigned ST_LOW_POWER_BIT = 1;
   localparam int unsigned ST_RESET_HELD_BIT = 2;

   // Flag fields: bit 0 reset complete, faults above
   localparam int unsigned FLAG_RESET_DONE_BIT = 0;
   localparam int unsigned FLAG_FAULT_LSB = 1;

   // Control fields
   localparam int unsigned CTRL_FORCE_LP_BIT = 0;
   localparam int unsigned CTRL_W = 1;

   // Reset values
   localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
   localparam logic [FLAG_W-1:0] MASK_RST = 5'h00;
   localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;

   typedef enum logic [2:0] {
      SCM_RUN  = 3'b001,
      SCM_HOLD = 3'b010,
      SCM_INIT = 3'b100
   } scm_state_t;

endpackage

/* scm_low_pulse_qual.sv */
// Purpose: Qualifies an active-low pulse by its length.
// Assumes: Input already synchronous to clk_i.
// Notes:   Reports a held-long-enough level and the release edge after it.
module scm_low_pulse_qual
   import scm_pkg::*;
#(
   parameter int unsigned MIN_CYCLES = RESET_MIN_CYC
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pin level
   input wire logic level_n_i,
   // Qualified results
   output logic qualified_o,
   output logic released_o
);
   import scm_pkg::*;

   typedef struct packed {
      logic [QCNT_W-1:0] cnt;
      logic qual;
      logic rel;
   } scm_qual_state_t;

   localparam logic [QCNT_W-1:0] MIN_CNT = QCNT_W'(MIN_CYCLES);
   localparam logic [QCNT_W-1:0] CNT_MAX = {QCNT_W{1'b1}};

   scm_qual_state_t s_q;
   scm_qual_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.rel = 1'b0;
      if (!level_n_i)
      begin
         if (s_q.cnt != CNT_MAX)
         begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
         // Strictly longer than the minimum
         if (s_q.cnt >= MIN_CNT)
         begin
            s_d.qual = 1'b1;
         end
      end
      else
      begin
         s_d.cnt = '0;
         s_d.qual = 1'b0;
         s_d.rel = s_q.qual;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign qualified_o = s_q.qual;
   assign released_o = s_q.rel;

endmodule

/* scm_sideband_ctrl_chk.sv */
// Purpose: Assertions on the sideband control ports.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound from the test top.
module scm_sideband_ctrl_chk
#(
   parameter int unsigned CLK_PER_MS = 4,
   parameter int unsigned T_INIT_MS = 3
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pins in
   input wire logic module_select_n_i,
   input wire logic module_select_drv_i,
   input wire logic module_reset_n_i,
   input wire logic module_reset_drv_i,
   input wire logic low_power_request_i,
   // Management port
   input wire logic mgmt_read_i,
   input wire logic [scm_pkg::DATA_W-1:0] mgmt_rdata_o,
   input wire logic mgmt_ack_o,
   // Pins out
   input wire logic module_present_n_o,
   input wire logic module_present_n_oe_o,
   input wire logic interrupt_out_n_o,
   input wire logic interrupt_out_n_oe_o,
   input wire logic low_power_o,
   input wire logic init_pending_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned INIT_LIM = CLK_PER_MS * T_INIT_MS + 4;
   logic pin_low;
   logic [8:0] low_cnt_q;
   logic [31:0] init_cnt_q;
   assign pin_low = module_reset_drv_i && !module_reset_n_i;
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || !pin_low)
         low_cnt_q <= 9'h000;
      else if (low_cnt_q != 9'h1FF)
         low_cnt_q <= low_cnt_q + 9'h001;
      if (!rst_n_i || pin_low || !init_pending_o)
         init_cnt_q <= 32'h0;
      else
         init_cnt_q <= init_cnt_q + 32'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_present_tied: assert property (module_present_n_oe_o && !module_present_n_o)
      else $error("presence pin not pulled low");
   a_irq_open_coll: assert property (!interrupt_out_n_o)
      else $error("interrupt pin drives high");
   a_sel_answer: assert property (mgmt_read_i && module_select_drv_i && !module_select_n_i
      |=> mgmt_ack_o) else $error("selected read not answered");
   a_desel_quiet: assert property (mgmt_read_i && (module_select_n_i || !module_select_drv_i)
      |=> !mgmt_ack_o && mgmt_rdata_o == 8'h00) else $error("deselected read answered");
   a_ack_cause: assert property (mgmt_ack_o |-> $past(mgmt_read_i))
      else $error("ack without read");
   a_lp_follow: assert property (low_power_request_i |=> low_power_o)
      else $error("low power not entered");
   a_done_irq: assert property ($fell(init_pending_o) |-> interrupt_out_n_oe_o)
      else $error("completion without interrupt");
   a_init_start: assert property ($rose(rst_n_i) |-> init_pending_o)
      else $error("init pending not set at power-up");
   a_init_bound: assert property (init_cnt_q <= INIT_LIM)
      else $error("init interval too long");
   a_long_reset: assert property (low_cnt_q > 9'h0CD |-> init_pending_o)
      else $error("long reset not taken");
   a_short_keep: assert property ($rose(init_pending_o) |-> $past(low_cnt_q) >= 9'h0C9)
      else $error("short reset pulse taken");
   cover property (mgmt_ack_o);
   cover property ($rose(interrupt_out_n_oe_o));
   cover property ($fell(init_pending_o));
endmodule

/* scm_host_model.sv */
// Purpose: Host board side of the sideband pins.
// Assumes: Pull-ups on host for open-collector lines.
// Notes: Undriven select and reset float high through the module pull-ups.
module scm_host_model
(
   // Host intent
   input wire logic sel_n_i,
   input wire logic sel_drv_i,
   input wire logic rst_n_i,
   input wire logic rst_drv_i,
   // Module open-collector outputs
   input wire logic irq_n_i,
   input wire logic irq_oe_i,
   input wire logic prs_n_i,
   input wire logic prs_oe_i,
   // Resolved pins
   output logic sel_pin_o,
   output logic rst_pin_o,
   output logic irq_line_o,
   output logic prs_line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign sel_pin_o = sel_drv_i ? sel_n_i : 1'b1;
   assign rst_pin_o = rst_drv_i ? rst_n_i : 1'b1;
   assign irq_line_o = irq_oe_i ? irq_n_i : 1'b1;
   assign prs_line_o = prs_oe_i ? prs_n_i : 1'b1;
endmodule

/* scm_sideband_ctrl_test.sv */
// Purpose: Self-checking test of the sideband control block.
// Assumes: Short init interval of 12 cycles.
// Notes: Host pins resolved by the host model.
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, a); end end
module scm_sideband_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   import scm_pkg::*;
   logic clk_i, rst_n_i, sel_lvl, sel_drv, rr_lvl, rr_drv, lp, wr, rd;
   logic sel_pin, rst_pin, irq_line, prs_line, ack, prs_n, prs_oe, irq_n, irq_oe;
   logic low_power_o, init_pending_o;
   logic [3:0] fault;
   logic [7:0] addr, wdata, rdata;
   int failures = 0;
   int compares = 0;
   int n;
   scm_sideband_ctrl #(.CLK_PER_MS(4), .T_INIT_MS(3)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .module_select_n_i(sel_pin), .module_select_drv_i(sel_drv), .module_reset_n_i(rst_pin),
      .module_reset_drv_i(rr_drv), .low_power_request_i(lp), .fault_event_i(fault),
      .mgmt_addr_i(addr), .mgmt_wdata_i(wdata), .mgmt_write_i(wr), .mgmt_read_i(rd),
      .mgmt_rdata_o(rdata), .mgmt_ack_o(ack), .module_present_n_o(prs_n),
      .module_present_n_oe_o(prs_oe), .interrupt_out_n_o(irq_n),
      .interrupt_out_n_oe_o(irq_oe), .low_power_o(low_power_o),
      .init_pending_o(init_pending_o));
   scm_host_model u_host (.sel_n_i(sel_lvl), .sel_drv_i(sel_drv), .rst_n_i(rr_lvl),
      .rst_drv_i(rr_drv), .irq_n_i(irq_n), .irq_oe_i(irq_oe), .prs_n_i(prs_n),
      .prs_oe_i(prs_oe), .sel_pin_o(sel_pin), .rst_pin_o(rst_pin),
      .irq_line_o(irq_line), .prs_line_o(prs_line));
   task automatic print_verdict();
      if (failures == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [8:0] e);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      `CHK("read", e, {ack, rdata})
   endtask
   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask
   task automatic wait_init(output int c);
      c = 0;
      while (init_pending_o !== 1'b0 && c < 100)
      begin
         tick();
         c++;
      end
      `CHK("done", 1'b0, init_pending_o)
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (5000) @(posedge clk_i);
      failures++;
      print_verdict();
   end
   initial
   begin
      {rst_n_i, sel_lvl, sel_drv, rr_lvl, rr_drv, lp, wr, rd} = 8'h20;
      fault = 4'h0;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      tick();
      `CHK("pend", 1'b1, init_pending_o)
      wait_init(n);
      `CHK("init", 1'b1, (n >= 11 && n <= 16))
      `CHK("irq", 1'b0, irq_line)
      `CHK("prs", 1'b0, prs_line)
      rd_chk(REG_FLAGS, 9'h101);
      wr_reg(REG_MASK, 8'h1F);
      wr_reg(REG_FLAGS, 8'h01);
      @(posedge clk_i);
      fault <= 4'hF;
      @(posedge clk_i);
      fault <= 4'h0;
      tick();
      `CHK("irq", 1'b1, irq_line)
      wr_reg(REG_MASK, 8'h00);
      tick();
      `CHK("irq", 1'b0, irq_line)
      rd_chk(REG_FLAGS, 9'h11E);
      wr_reg(REG_FLAGS, 8'h1E);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk_i);
         sel_drv <= (i == 0);
         sel_lvl <= (i == 0);
         wr_reg(REG_MASK, 8'h1F);
         rd_chk(REG_MASK, 9'h000);
      end
      @(posedge clk_i);
      sel_drv <= 1'b1;
      sel_lvl <= 1'b0;
      rd_chk(REG_MASK, 9'h100);
      rd_chk(8'h04, 9'h100);
      `CHK("irq", 1'b1, irq_line)
      @(posedge clk_i);
      lp <= 1'b1;
      tick();
      tick();
      `CHK("lp", 1'b1, low_power_o)
      rd_chk(REG_STATUS, 9'h102);
      @(posedge clk_i);
      lp <= 1'b0;
      wr_reg(REG_CONTROL, 8'h01);
      tick();
      `CHK("lp", 1'b1, low_power_o)
      wr_reg(REG_CONTROL, 8'h00);
      tick();
      `CHK("lp", 1'b0, low_power_o)
      wr_reg(REG_MASK, 8'h03);
      @(posedge clk_i);
      rr_drv <= 1'b1;
      rr_lvl <= 1'b0;
      repeat (100) @(posedge clk_i);
      rr_lvl <= 1'b1;
      repeat (20) @(posedge clk_i);
      rd_chk(REG_MASK, 9'h103);
      @(posedge clk_i);
      rr_lvl <= 1'b0;
      repeat (210) tick();
      `CHK("pend", 1'b1, init_pending_o)
      rd_chk(REG_STATUS, 9'h105);
      @(posedge clk_i);
      rr_lvl <= 1'b1;
      wait_init(n);
      `CHK("init", 1'b1, (n >= 12 && n <= 16))
      rd_chk(REG_MASK, 9'h100);
      rd_chk(REG_FLAGS, 9'h101);
      `CHK("irq", 1'b0, irq_line)
      print_verdict();
   end
endmodule
bind scm_sideband_ctrl scm_sideband_ctrl_chk #(.CLK_PER_MS(CLK_PER_MS), .T_INIT_MS(T_INIT_MS))
   u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .module_select_n_i(module_select_n_i),
   .module_select_drv_i(module_select_drv_i), .module_reset_n_i(module_reset_n_i),
   .module_reset_drv_i(module_reset_drv_i), .low_power_request_i(low_power_request_i),
   .mgmt_read_i(mgmt_read_i), .mgmt_rdata_o(mgmt_rdata_o), .mgmt_ack_o(mgmt_ack_o),
   .module_present_n_o(module_present_n_o), .module_present_n_oe_o(module_present_n_oe_o),
   .interrupt_out_n_o(interrupt_out_n_o), .interrupt_out_n_oe_o(interrupt_out_n_oe_o),
   .low_power_o(low_power_o), .init_pending_o(init_pending_o));
